//--- logic/dfd_cfg.svh
// Purpose: Offsets, field positions, reset values and counts for the fan duty
//          control block.
// Assumes: Wishbone byte address is four times the register index.
// Notes:   Definitions only.
`ifndef DFD_CFG_SVH
`define DFD_CFG_SVH

// Register indices; byte address is index * 4
`define DFD_IDX_CHAN_A 10'h056
`define DFD_IDX_CHAN_B 10'h057
`define DFD_IDX_FANCTL 10'h058
`define DFD_IDX_STATUS 10'h059

// Reset values
`define DFD_RST_CHAN 8'h00
`define DFD_RST_FANCTL 8'h50

// Shared fan control fields
`define DFD_FC_SRC_A 0
`define DFD_FC_SRC_B 1
`define DFD_FC_DBL_A 2
`define DFD_FC_DBL_B 3

// Status fields
`define DFD_ST_PIN_LSB 0
`define DFD_ST_SLOT_A_LSB 8
`define DFD_ST_SLOT_B_LSB 16

// Duty period
`define DFD_SLOT_W 6
`define DFD_LAST_SLOT 6'h3f

`endif

//--- logic/dfd_pkg.sv
// Purpose: Types shared by the fan duty control block.
// Assumes: Nothing beyond the config header.
// Notes:   Channel control layout mirrors the 8-bit channel register.
package dfd_pkg;

   // One channel register: clock select, duty field, force-high
   typedef struct packed {
      logic clk_sel;
      logic [5:0] duty;
      logic force_high;
   } dfd_chan_type;

   // Settings latched at a period boundary
   typedef struct packed {
      logic force_high;
      logic [5:0] duty;
   } dfd_shadow_type;

   // Per-channel frequency selection
   typedef struct packed {
      logic src_sel;
      logic clk_sel;
      logic dbl;
   } dfd_freq_type;

endpackage : dfd_pkg

//--- logic/dfd_rate_gen.sv
// Purpose: Slot tick generator: one pulse every div_i clock cycles.
// Assumes: div_i is at least 1; a smaller new divisor takes effect at once.
// Notes:   Counter restarts when it reaches or passes the divisor minus one.
`timescale 1ns/100ps
`default_nettype none
module dfd_rate_gen #(
   parameter int DIV_W = 16
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Divisor and tick
   input wire logic [DIV_W-1:0] div_i,
   output logic tick_o
);
   logic [DIV_W-1:0] cnt_ff;
   logic [DIV_W-1:0] nxt_cnt;
   logic tick_ff;
   logic nxt_tick;

   always_comb begin
      nxt_tick = 1'b0;
      nxt_cnt = cnt_ff + {{(DIV_W-1){1'b0}}, 1'b1};
      if (cnt_ff >= div_i - {{(DIV_W-1){1'b0}}, 1'b1}) begin
         nxt_cnt = '0;
         nxt_tick = 1'b1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cnt_ff <= '0;
         tick_ff <= 1'b0;
      end else begin
         cnt_ff <= nxt_cnt;
         tick_ff <= nxt_tick;
      end
   end

   assign tick_o = tick_ff;
endmodule : dfd_rate_gen
`default_nettype wire

//--- logic/dfd_pwm_chan.sv
// Purpose: One 64-slot duty channel driving a fan pin.
// Assumes: slot_tick_i is a one-cycle pulse per slot.
// Notes:   Settings are taken only at the first slot of a period.
`timescale 1ns/100ps
`default_nettype none
`include "dfd_cfg.svh"
module dfd_pwm_chan (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Settings and timing
   input wire dfd_pkg::dfd_chan_type ctl_i,
   input wire logic slot_tick_i,
   // Pin and state
   output logic pin_o,
   output logic [5:0] slot_o
);
   import dfd_pkg::*;

   logic [5:0] slot_ff;
   logic [5:0] nxt_slot;
   dfd_shadow_type shd_ff;
   dfd_shadow_type nxt_shd;
   logic pin_ff;
   logic nxt_pin;

   always_comb begin
      nxt_slot = slot_ff;
      nxt_shd = shd_ff;
      nxt_pin = pin_ff;
      if (slot_tick_i) begin
         if (slot_ff == `DFD_LAST_SLOT) begin
            nxt_slot = '0;
            // New setting only at period start
            nxt_shd.force_high = ctl_i.force_high;
            nxt_shd.duty = ctl_i.duty;
         end else begin
            nxt_slot = slot_ff + 6'h01;
         end
         // High while slot index is below duty code
         if (nxt_shd.force_high) begin
            nxt_pin = 1'b1;
         end else begin
            nxt_pin = (nxt_slot < nxt_shd.duty);
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         slot_ff <= `DFD_LAST_SLOT;
         shd_ff <= '0;
         pin_ff <= 1'b0;
      end else begin
         slot_ff <= nxt_slot;
         shd_ff <= nxt_shd;
         pin_ff <= nxt_pin;
      end
   end

   assign pin_o = pin_ff;
   assign slot_o = slot_ff;
endmodule : dfd_pwm_chan
`default_nettype wire

//--- logic/dfd_top.sv
// Purpose: Two-channel fan duty output generator with Wishbone registers.
// Assumes: Classic Wishbone slave, 32-bit data, writable registers in the low byte; status read uses bits 0 to 21.
// Notes:   Each pin period is 64 slots; slot rate comes from a lookup.
//
// How it works
// - Channel A bit0 forces pin high, else duty.
// - Channel B behaves identically from own register.
// - Duty zero low always; all ones 63/1.
// - Code 100000 gives half; high proportional of 64.
// - Channel A rate from clock select, source, doubler.
// - Channel B rate from clock select, source, doubler.
// - Shared bit 2 doubles channel A rate.
// - Shared bit 3 doubles channel B rate.
// - Doubler clear means no multiplication applied.
//
// The Wishbone slave port was left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "dfd_cfg.svh"
module dfd_top #(
   parameter int ADR_W = 12,
   parameter int DIV_W = 16,
   // Clock cycles per slot, index {source select, clock select}
   parameter logic [DIV_W-1:0] SLOT_DIV_0 = 16'h0f00,
   parameter logic [DIV_W-1:0] SLOT_DIV_1 = 16'h0780,
   parameter logic [DIV_W-1:0] SLOT_DIV_2 = 16'h0100,
   parameter logic [DIV_W-1:0] SLOT_DIV_3 = 16'h0080
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [ADR_W-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Fan pins
   output logic cooler_drive_a_o,
   output logic cooler_drive_b_o
);
   import dfd_pkg::*;

   localparam int NCH = 2;

   ////////////////////////////////////////////////////////////////////////////
   // Helpers

   // Word index of a byte address
   function automatic logic [9:0] word_index(input logic [ADR_W-1:0] adr);
      logic [ADR_W-1:0] w;
      w = adr >> 2;
      return w[9:0];
   endfunction : word_index

   // Base slot divisor from the lookup, then optional halving
   function automatic logic [DIV_W-1:0] slot_div(input dfd_freq_type f);
      logic [DIV_W-1:0] base;
      logic [DIV_W-1:0] res;
      base = SLOT_DIV_0;
      unique case ({f.src_sel, f.clk_sel})
         2'b00: base = SLOT_DIV_0;
         2'b01: base = SLOT_DIV_1;
         2'b10: base = SLOT_DIV_2;
         2'b11: base = SLOT_DIV_3;
      endcase
      res = base;
      if (f.dbl) begin
         // Twice the frequency is half the slot length
         res = base >> 1;
      end
      if (res == '0) begin
         res = {{(DIV_W-1){1'b0}}, 1'b1};
      end
      return res;
   endfunction : slot_div

   // Frequency settings of one channel from its register and the shared bits
   function automatic dfd_freq_type chan_freq(input logic [7:0] fc,
      input dfd_chan_type ch, input logic sec);
      dfd_freq_type f;
      f.clk_sel = ch.clk_sel;
      if (sec) begin
         f.src_sel = fc[`DFD_FC_SRC_B];
         f.dbl = fc[`DFD_FC_DBL_B];
      end else begin
         f.src_sel = fc[`DFD_FC_SRC_A];
         f.dbl = fc[`DFD_FC_DBL_A];
      end
      return f;
   endfunction : chan_freq

   ////////////////////////////////////////////////////////////////////////////
   // Register decode and status packing

   // One-hot select of the mapped words: chan A, chan B, control, status
   function automatic logic [3:0] reg_hit(input logic [9:0] idx);
      logic [3:0] hit;
      hit[0] = (idx == `DFD_IDX_CHAN_A);
      hit[1] = (idx == `DFD_IDX_CHAN_B);
      hit[2] = (idx == `DFD_IDX_FANCTL);
      hit[3] = (idx == `DFD_IDX_STATUS);
      return hit;
   endfunction : reg_hit

   // Status word: pin levels and slot positions of both channels
   function automatic logic [31:0] status_word(input logic [NCH-1:0] pins,
      input logic [5:0] sa, input logic [5:0] sb);
      logic [31:0] w;
      w = '0;
      w[`DFD_ST_PIN_LSB +: NCH] = pins;
      w[`DFD_ST_SLOT_A_LSB +: 6] = sa;
      w[`DFD_ST_SLOT_B_LSB +: 6] = sb;
      return w;
   endfunction : status_word

   ////////////////////////////////////////////////////////////////////////////
   // Register state

   dfd_chan_type chan_a_ff;
   dfd_chan_type chan_b_ff;
   logic [7:0] fanctl_ff;
   dfd_chan_type nxt_chan_a;
   dfd_chan_type nxt_chan_b;
   logic [7:0] nxt_fanctl;

   // Bus answer state
   logic ack_ff;
   logic nxt_ack;
   logic [31:0] rdat_ff;
   logic [31:0] nxt_rdat;

   // Channel state
   logic [NCH-1:0] pin_w;
   logic [5:0] slot_w [NCH];
   dfd_chan_type ctl_w [NCH];
   dfd_freq_type freq_w [NCH];
   logic [NCH-1:0] tick_w;
   // Divisor per channel
   logic [DIV_W-1:0] div_ff [NCH];
   logic [DIV_W-1:0] nxt_div [NCH];

   // Pin output state
   logic [NCH-1:0] pin_ff;
   logic [NCH-1:0] nxt_pin;

   logic req_w;
   logic wr_w;
   logic [9:0] idx_w;
   logic [3:0] hit_w;

   assign req_w = wb_cyc_i & wb_stb_i & ~ack_ff;
   assign wr_w = req_w & wb_we_i & wb_sel_i[0];
   assign idx_w = word_index(wb_adr_i);
   // Register hit of the current request
   assign hit_w = reg_hit(idx_w);

   ////////////////////////////////////////////////////////////////////////////
   // Register writes

   always_comb begin
      nxt_chan_a = chan_a_ff;
      nxt_chan_b = chan_b_ff;
      nxt_fanctl = fanctl_ff;
      // Registers live in the low byte lane
      if (wr_w) begin
         if (hit_w[0]) begin
            nxt_chan_a = dfd_chan_type'(wb_dat_i[7:0]);
         end
         if (hit_w[1]) begin
            nxt_chan_b = dfd_chan_type'(wb_dat_i[7:0]);
         end
         if (hit_w[2]) begin
            nxt_fanctl = wb_dat_i[7:0];
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         chan_a_ff <= dfd_chan_type'(`DFD_RST_CHAN);
         chan_b_ff <= dfd_chan_type'(`DFD_RST_CHAN);
         fanctl_ff <= `DFD_RST_FANCTL;
      end else begin
         chan_a_ff <= nxt_chan_a;
         chan_b_ff <= nxt_chan_b;
         fanctl_ff <= nxt_fanctl;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Bus answer and read data

   always_comb begin
      nxt_ack = req_w;
      nxt_rdat = '0;
      if (req_w && !wb_we_i) begin
         unique case (1'b1)
            hit_w[0]: nxt_rdat[7:0] = chan_a_ff;
            hit_w[1]: nxt_rdat[7:0] = chan_b_ff;
            hit_w[2]: nxt_rdat[7:0] = fanctl_ff;
            hit_w[3]: nxt_rdat = status_word(pin_ff, slot_w[0], slot_w[1]);
            // Unmapped words answer with zero
            default: nxt_rdat = '0;
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_ff <= 1'b0;
         rdat_ff <= '0;
      end else begin
         ack_ff <= nxt_ack;
         rdat_ff <= nxt_rdat;
      end
   end

   assign wb_ack_o = ack_ff;
   assign wb_dat_o = rdat_ff;

   ////////////////////////////////////////////////////////////////////////////
   // Frequency selection per channel

   always_comb begin
      ctl_w[0] = chan_a_ff;
      ctl_w[1] = chan_b_ff;
      // Source, clock select and doubler for channel A
      freq_w[0] = chan_freq(fanctl_ff, chan_a_ff, 1'b0);
      // Source, clock select and doubler for channel B
      freq_w[1] = chan_freq(fanctl_ff, chan_b_ff, 1'b1);
   end

   ////////////////////////////////////////////////////////////////////////////
   // Slot divisor per channel

   // Lookup then optional doubling; clear doubler leaves base
   always_comb begin
      for (int c = 0; c < NCH; c++) begin
         nxt_div[c] = slot_div(freq_w[c]);
      end
   end

   // Registered so the lookup stays out of the tick counter's compare path
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         for (int c = 0; c < NCH; c++) begin
            // Divisor of the reset settings
            div_ff[c] <= SLOT_DIV_0;
         end
      end else begin
         for (int c = 0; c < NCH; c++) begin
            div_ff[c] <= nxt_div[c];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Channels

   for (genvar c = 0; c < NCH; c++) begin : g_chan
      dfd_rate_gen #(
         .DIV_W(DIV_W)
      ) u_rate (
         .clk_i(clk_i),
         .rst_i(rst_i),
         .div_i(div_ff[c]),
         .tick_o(tick_w[c])
      );

      dfd_pwm_chan u_pwm (
         .clk_i(clk_i),
         .rst_i(rst_i),
         .ctl_i(ctl_w[c]),
         .slot_tick_i(tick_w[c]),
         .pin_o(pin_w[c]),
         .slot_o(slot_w[c])
      );
   end

   ////////////////////////////////////////////////////////////////////////////
   // Pin outputs

   // Pins leave the block from a flop of this module
   always_comb begin
      nxt_pin = pin_w;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pin_ff <= '0;
      end else begin
         pin_ff <= nxt_pin;
      end
   end

   assign cooler_drive_a_o = pin_ff[0];
   assign cooler_drive_b_o = pin_ff[1];

endmodule : dfd_top
`default_nettype wire

//--- tb/dfd_checker.sv
// Purpose: Bus and pin checks on the dfd_top ports.
// Assumes: One clock, reset high.
// Notes: Bound after the module.
`timescale 1ns/100ps
`default_nettype none
module dfd_checker #(parameter int ADR_W = 12) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Bus and pins
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [ADR_W-1:0] wb_adr_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic cooler_drive_a_o,
   input wire logic cooler_drive_b_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   ack_resp_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("request not acked");
   ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack too long");
   ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
      else $error("ack without request");
   dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
      else $error("data outside ack");
   wr_dat_a: assert property (wb_ack_o && $past(wb_we_i) |-> wb_dat_o == 32'h0)
      else $error("data on write ack");
   unmap_zero_a: assert property (wb_ack_o && !$past(wb_we_i) &&
      !($past(wb_adr_i) inside {[12'h158:12'h167]}) |-> wb_dat_o == 32'h0)
      else $error("unmapped read not zero");
   pin_a_rst_a: assert property ($past(rst_i) |-> !cooler_drive_a_o)
      else $error("pin a high after reset");
   pin_b_rst_a: assert property ($past(rst_i) |-> !cooler_drive_b_o)
      else $error("pin b high after reset");
endmodule : dfd_checker
bind dfd_top dfd_checker #(.ADR_W(ADR_W)) i_chk (.clk_i(clk_i), .rst_i(rst_i),
   .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
   .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
   .cooler_drive_a_o(cooler_drive_a_o), .cooler_drive_b_o(cooler_drive_b_o));
`default_nettype wire

//--- tb/dfd_fan_model.sv
// Purpose: Fan drive load that counts pin high cycles in a window.
// Assumes: start_i is a one-cycle pulse.
// Notes: Behavioural.
`timescale 1ns/100ps
`default_nettype none
module dfd_fan_model (
   // Clock
   input wire logic clk_i,
   // Pin and window
   input wire logic pin_i,
   input wire logic start_i,
   input wire logic [31:0] win_i,
   output int hi_o,
   output logic busy_o
);
   int left;
   initial begin
      hi_o = 0;
      busy_o = 1'b0;
      left = 0;
   end
   always @(posedge clk_i) begin
      if (start_i) begin
         hi_o <= 0;
         left <= int'(win_i);
         busy_o <= 1'b1;
      end else if (left > 0) begin
         hi_o <= hi_o + int'(pin_i);
         left <= left - 1;
         busy_o <= left > 1;
      end
   end
endmodule : dfd_fan_model
`default_nettype wire

//--- tb/dual_fan_duty_control_tb_top.sv
// Purpose: Self-checking bench for dfd_top.
// Assumes: Slot lengths 4, 2, 8, 6 cycles.
// Notes: High count over one period equals duty times slot length, or 64 times slot length when forced high.
`timescale 1ns/100ps
`default_nettype none
module dual_fan_duty_control_tb_top;
   logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
   logic [11:0] adr = 12'h0;
   logic [3:0] sel = 4'h0;
   logic [31:0] wdat = 32'h0, rdat, lfsr = 32'h4591;
   logic ack, pin_a, pin_b;
   logic [1:0] start = 2'b00;
   logic [31:0] win [2] = '{32'h1, 32'h1};
   int hi [2];
   logic busy [2];
   int n_fail = 0, compares = 0;
   int divs [4] = '{4, 2, 8, 6};
   // Register model: channel A, channel B, shared control
   int mdl [3] = '{0, 0, 'h50};
   initial begin
      forever #4 clk_i = ~clk_i;
   end
   dfd_top #(.SLOT_DIV_0(16'h0004), .SLOT_DIV_1(16'h0002),
      .SLOT_DIV_2(16'h0008), .SLOT_DIV_3(16'h0006)) i_dut (.clk_i(clk_i),
      .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
      .wb_ack_o(ack), .cooler_drive_a_o(pin_a), .cooler_drive_b_o(pin_b));
   dfd_fan_model i_fan_a (.clk_i(clk_i), .pin_i(pin_a), .start_i(start[0]),
      .win_i(win[0]), .hi_o(hi[0]), .busy_o(busy[0]));
   dfd_fan_model i_fan_b (.clk_i(clk_i), .pin_i(pin_b), .start_i(start[1]),
      .win_i(win[1]), .hi_o(hi[1]), .busy_o(busy[1]));
   function automatic logic [31:0] nxt(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction : nxt
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         n_fail++;
         $display("unexpected at %0t: got %h want %h", $time, seen, exp);
      end
   endtask : check
   task automatic end_of_test;
      $display("fails %0d compares %0d", n_fail, compares);
      if (n_fail == 0 && compares > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : end_of_test
   task automatic bus(input logic w, input logic [11:0] a,
      input logic [7:0] d, output logic [31:0] q);
      int i;
      i = int'(a[11:2]) - int'(10'h056);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      sel <= 4'h1;
      wdat <= {lfsr[23:0], d};
      do begin
         @(posedge clk_i);
      end while (ack !== 1'b1);
      q = rdat;
      if (w && i >= 0 && i < 3) mdl[i] = d;
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clk_i);
   endtask : bus
   initial begin
      #320000;
      n_fail++;
      end_of_test();
   end
   initial begin
      logic [31:0] q;
      logic [7:0] ca, cb;
      int k, m, t, da, db, ea, eb;
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      bus(1'b0, 12'h158, 8'h0, q);
      check(q, 32'(mdl[0]));
      bus(1'b0, 12'h15c, 8'h0, q);
      check(q, 32'(mdl[1]));
      bus(1'b0, 12'h160, 8'h0, q);
      check(q, 32'(mdl[2]));
      bus(1'b0, 12'h010, 8'h0, q);
      check(q, 32'h0);
      for (k = 0; k < 8; k++) begin
         lfsr = nxt(lfsr);
         m = 7 - k;
         ca = {k[1], (k == 0) ? 6'h0 : (k == 1) ? 6'h20 : (k == 2) ? 6'h3f :
            lfsr[5:0], k == 7};
         cb = {m[1], ~ca[6:1], k == 7};
         da = divs[k[2] * 2 + k[1]] >> k[0];
         db = divs[m[2] * 2 + m[1]] >> m[0];
         bus(1'b1, 12'h160, {4'h5, m[0], k[0], m[2], k[2]}, q);
         bus(1'b1, 12'h158, ca, q);
         bus(1'b1, 12'h15c, cb, q);
         bus(1'b0, 12'h158, 8'h0, q);
         check(q, 32'(mdl[0]));
         bus(1'b0, 12'h15c, 8'h0, q);
         check(q, 32'(mdl[1]));
         repeat (1200) @(posedge clk_i);
         win[0] <= 32'(64 * da);
         win[1] <= 32'(64 * db);
         start <= 2'b11;
         @(posedge clk_i);
         start <= 2'b00;
         @(posedge clk_i);
         t = 0;
         do begin
            @(posedge clk_i);
            t++;
         end while ((busy[0] || busy[1]) && t < 2000);
         if (t >= 2000) n_fail++;
         ea = (ca[0] ? 64 : ca[6:1]) * da;
         eb = (cb[0] ? 64 : cb[6:1]) * db;
         check(32'(hi[0]), 32'(ea));
         check(32'(hi[1]), 32'(eb));
      end
      end_of_test();
   end
endmodule : dual_fan_duty_control_tb_top
`default_nettype wire
